// ---- rtl/rtc_pkg.sv ----
package rtc_pkg;

  // Register offsets of the time and date bank
  localparam logic [7:0] SEC_ADDR  = 8'h04;
  localparam logic [7:0] MIN_ADDR  = 8'h05;
  localparam logic [7:0] HOUR_ADDR = 8'h06;
  localparam logic [7:0] DAY_ADDR  = 8'h07;
  localparam logic [7:0] WDAY_ADDR = 8'h08;
  localparam logic [7:0] MON_ADDR  = 8'h09;
  localparam logic [7:0] YEAR_ADDR = 8'h0a;

  // Field positions
  localparam int OS_BIT       = 7;
  localparam int MERIDIEM_BIT = 5;

  // Reset values; the oscillator counts as stopped after power-on
  localparam logic [7:0] SEC_RST  = 8'h80;
  localparam logic [7:0] MIN_RST  = 8'h00;
  localparam logic [7:0] HOUR_RST = 8'h00;
  localparam logic [7:0] DAY_RST  = 8'h01;
  localparam logic [7:0] WDAY_RST = 8'h06;
  localparam logic [7:0] MON_RST  = 8'h01;
  localparam logic [7:0] YEAR_RST = 8'h00;

  // Writable bits of each register but the year; the rest read as zero, except seconds bit 7, the halt flag
  localparam logic [7:0] SEC_MASK  = 8'h7f;
  localparam logic [7:0] MIN_MASK  = 8'h7f;
  localparam logic [7:0] HOUR_MASK = 8'h3f;
  localparam logic [7:0] DAY_MASK  = 8'h3f;
  localparam logic [7:0] WDAY_MASK = 8'h07;
  localparam logic [7:0] MON_MASK  = 8'h1f;

  // BCD count limits
  localparam logic [7:0] SEC_LAST  = 8'h59;
  localparam logic [7:0] MIN_LAST  = 8'h59;
  localparam logic [7:0] H24_LAST  = 8'h23;
  localparam logic [4:0] H12_ELEVEN = 5'h11;
  localparam logic [4:0] H12_TWELVE = 5'h12;
  localparam logic [4:0] H12_FIRST  = 5'h01;
  localparam logic [7:0] MON_LAST  = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [2:0] WDAY_LAST = 3'h6;
  localparam logic [7:0] FEB_BCD   = 8'h02;
  localparam logic [7:0] DAYS_28   = 8'h28;
  localparam logic [7:0] DAYS_29   = 8'h29;
  localparam logic [7:0] DAYS_30   = 8'h30;
  localparam logic [7:0] DAYS_31   = 8'h31;

  // Timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int LINK_PERIOD_NS = 125;

endpackage

// ---- rtl/rtc_time_date_counters.sv ----
`timescale 1ns/1ps
module rtc_time_date_counters (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_1hz_i,
  input  wire logic       osc_running_i,
  input  wire logic       hour_12_mode_i,
  input  wire logic       link_clk_i,
  input  wire logic       access_active_i,
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  output logic            reg_busy_o,
  output logic            osc_halt_flag_o
);
  import rtc_pkg::*;

  // Core domain state
  logic [7:0] sec_reg, min_reg, hour_reg, day_reg, wday_reg, mon_reg, year_reg;
  logic [7:0] sec_next, min_next, hour_next, day_next, wday_next, mon_next, year_next;
  logic       act_s1, act_s2, osc_s1, osc_s2;
  logic       tk_s1, tk_s2, tk_s3;
  logic       req_s1, req_s2, req_s3;
  logic       ack_reg, pending_reg;
  logic [7:0] rd_hold_reg;
  logic       blocked, tick_evt, do_inc, req_evt, wr_evt, rd_evt;
  logic       c_min, c_hour, c_day, c_mon, c_year;
  logic [7:0] day_last, sec_step, hour_step;

  // Link domain state
  logic       lrst_s1, lrst_s2;
  logic       l_req_reg, l_rw_reg;
  logic [7:0] l_addr_reg, l_wdata_reg;
  logic       lack_s1, lack_s2, lack_s3;

  function automatic logic [7:0] bcd_step(input logic [7:0] v);
    if (v[3:0] == 4'h9)
    begin
      bcd_step = {v[7:4] + 4'h1, 4'h0};
    end
    else
    begin
      bcd_step = v + 8'h01;
    end
  endfunction

  function automatic logic leap_year(input logic [7:0] y);
    if (!y[4])
    begin
      leap_year = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end
    else
    begin
      leap_year = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
  endfunction

  // Synchronisers; logic reads the second flop of each chain, and also the third of the tick and request chains
  always_ff @(posedge clk_i)
  begin
    act_s1 <= access_active_i;
    act_s2 <= act_s1;
    osc_s1 <= osc_running_i;
    osc_s2 <= osc_s1;
    tk_s1  <= tick_1hz_i;
    tk_s2  <= tk_s1;
    tk_s3  <= tk_s2;
    req_s1 <= l_req_reg;
    req_s2 <= req_s1;
    req_s3 <= req_s2;
  end

  assign blocked  = act_s2;
  assign tick_evt = tk_s2 & ~tk_s3;
  assign do_inc   = ~blocked & (tick_evt | pending_reg);
  assign req_evt  = req_s2 ^ req_s3;
  assign wr_evt   = req_evt & l_rw_reg;
  assign rd_evt   = req_evt & ~l_rw_reg;

  // A second tick inside one access is dropped, so accesses must stay short
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pending_reg <= 1'b0;
    end
    else if (blocked && tick_evt)
    begin
      pending_reg <= 1'b1;
    end
    else if (!blocked)
    begin
      pending_reg <= 1'b0;
    end
  end

  // Calendar increment chain
  always_comb
  begin
    day_last = DAYS_31;
    sec_step  = bcd_step({1'b0, sec_reg[6:0]});
    hour_step = bcd_step({3'b000, hour_reg[4:0]});
    if (mon_reg == FEB_BCD)
    begin
      day_last = leap_year(year_reg) ? DAYS_29 : DAYS_28;
    end
    else if (mon_reg == 8'h04 || mon_reg == 8'h06 || mon_reg == 8'h09 || mon_reg == 8'h11)
    begin
      day_last = DAYS_30;
    end
    c_min    = (sec_reg[6:0] == SEC_LAST[6:0]);
    sec_next = {sec_reg[OS_BIT], c_min ? 7'h00 : sec_step[6:0]};
    c_hour   = c_min & (min_reg == MIN_LAST);
    min_next = c_hour ? 8'h00 : bcd_step(min_reg);
    if (hour_12_mode_i)
    begin
      c_day = c_hour & hour_reg[MERIDIEM_BIT] & (hour_reg[4:0] == H12_ELEVEN);
      if (hour_reg[4:0] == H12_ELEVEN)
      begin
        hour_next = {2'b00, ~hour_reg[MERIDIEM_BIT], H12_TWELVE};
      end
      else if (hour_reg[4:0] == H12_TWELVE)
      begin
        hour_next = {2'b00, hour_reg[MERIDIEM_BIT], H12_FIRST};
      end
      else
      begin
        hour_next = {2'b00, hour_reg[MERIDIEM_BIT], hour_step[4:0]};
      end
    end
    else
    begin
      c_day     = c_hour & (hour_reg == H24_LAST);
      hour_next = c_day ? 8'h00 : bcd_step(hour_reg);
    end
    c_mon     = c_day & (day_reg == day_last);
    day_next  = c_mon ? DAY_RST : bcd_step(day_reg);
    wday_next = (wday_reg[2:0] == WDAY_LAST) ? 8'h00 : {5'h00, wday_reg[2:0] + 3'h1};
    c_year    = c_mon & (mon_reg == MON_LAST);
    mon_next  = c_year ? MON_RST : bcd_step(mon_reg);
    year_next = (year_reg == YEAR_LAST) ? 8'h00 : bcd_step(year_reg);
  end

  // Counter registers: reset, host write, or tick
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sec_reg  <= SEC_RST;
      min_reg  <= MIN_RST;
      hour_reg <= HOUR_RST;
      day_reg  <= DAY_RST;
      wday_reg <= WDAY_RST;
      mon_reg  <= MON_RST;
      year_reg <= YEAR_RST;
    end
    else if (wr_evt)
    begin
      if (l_addr_reg == SEC_ADDR)
        sec_reg <= l_wdata_reg & SEC_MASK;
      else if (l_addr_reg == MIN_ADDR)
        min_reg <= l_wdata_reg & MIN_MASK;
      else if (l_addr_reg == HOUR_ADDR)
        hour_reg <= l_wdata_reg & HOUR_MASK;
      else if (l_addr_reg == DAY_ADDR)
        day_reg <= l_wdata_reg & DAY_MASK;
      else if (l_addr_reg == WDAY_ADDR)
        wday_reg <= l_wdata_reg & WDAY_MASK;
      else if (l_addr_reg == MON_ADDR)
        mon_reg <= l_wdata_reg & MON_MASK;
      else if (l_addr_reg == YEAR_ADDR)
        year_reg <= l_wdata_reg;
    end
    else if (do_inc)
    begin
      sec_reg <= sec_next;
      if (c_min)
      begin
        min_reg <= min_next;
      end
      if (c_hour)
      begin
        hour_reg <= hour_next;
      end
      if (c_day)
      begin
        day_reg  <= day_next;
        wday_reg <= wday_next;
      end
      if (c_mon)
      begin
        mon_reg <= mon_next;
      end
      if (c_year)
      begin
        year_reg <= year_next;
      end
    end
  end

  // Halt flag: a stopped oscillator wins over a host clear in the same cycle
  logic os_reg;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      os_reg <= 1'b1;
    end
    else if (!osc_s2)
    begin
      os_reg <= 1'b1;
    end
    else if (wr_evt && l_addr_reg == SEC_ADDR)
    begin
      os_reg <= l_wdata_reg[OS_BIT];
    end
  end
  assign osc_halt_flag_o = os_reg;

  // Read capture and acknowledge toggle back to the link
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_reg     <= 1'b0;
      rd_hold_reg <= 8'h00;
    end
    else if (req_evt)
    begin
      ack_reg <= ~ack_reg;
      if (rd_evt)
      begin
        if (l_addr_reg == SEC_ADDR)
          rd_hold_reg <= {os_reg, sec_reg[6:0]};
        else if (l_addr_reg == MIN_ADDR)
          rd_hold_reg <= min_reg;
        else if (l_addr_reg == HOUR_ADDR)
          rd_hold_reg <= hour_reg;
        else if (l_addr_reg == DAY_ADDR)
          rd_hold_reg <= day_reg;
        else if (l_addr_reg == WDAY_ADDR)
          rd_hold_reg <= wday_reg;
        else if (l_addr_reg == MON_ADDR)
          rd_hold_reg <= mon_reg;
        else if (l_addr_reg == YEAR_ADDR)
          rd_hold_reg <= year_reg;
        else
          rd_hold_reg <= 8'h00;
      end
    end
  end

  // Link domain: reset synchroniser and toggle handshake
  always_ff @(posedge link_clk_i)
  begin
    lrst_s1 <= rst_i;
    lrst_s2 <= lrst_s1;
    lack_s1 <= ack_reg;
    lack_s2 <= lack_s1;
    lack_s3 <= lack_s2;
  end

  // New requests are ignored while the previous one is in flight
  always_ff @(posedge link_clk_i)
  begin
    if (lrst_s2)
    begin
      l_req_reg   <= 1'b0;
      l_rw_reg    <= 1'b0;
      l_addr_reg  <= 8'h00;
      l_wdata_reg <= 8'h00;
    end
    else if (!reg_busy_o && (reg_wr_i || reg_rd_i))
    begin
      l_req_reg   <= ~l_req_reg;
      l_rw_reg    <= reg_wr_i;
      l_addr_reg  <= reg_addr_i;
      l_wdata_reg <= reg_wdata_i;
    end
  end

  always_ff @(posedge link_clk_i)
  begin
    if (lrst_s2)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (lack_s2 ^ lack_s3)
    begin
      reg_rdata_o <= rd_hold_reg;
    end
  end

  assign reg_busy_o = l_req_reg ^ lack_s3;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_os_sets_stopped: assert property (!osc_s2 |=> os_reg) else $error("halt flag not set");
  a_os_holds_set: assert property (os_reg && !(wr_evt && l_addr_reg == SEC_ADDR) |=> os_reg)
    else $error("halt flag cleared without write");
  a_os_clear_fails: assert property (wr_evt && l_addr_reg == SEC_ADDR && !osc_s2 |=> os_reg)
    else $error("halt flag cleared while stopped");
  a_block_freezes_time: assert property (blocked && !wr_evt |=> $stable({sec_reg, min_reg, hour_reg, day_reg}))
    else $error("counters moved during access");
  a_pending_one_tick: assert property (blocked && tick_evt |=> pending_reg)
    else $error("tick during access not held");
  a_release_services: assert property (!blocked |=> !pending_reg)
    else $error("pending tick not serviced");
  a_sec_wraps: assert property (do_inc && !wr_evt && sec_reg[6:0] == SEC_LAST[6:0] |=> sec_reg[6:0] == 7'h00)
    else $error("seconds did not wrap");
  a_min_bit_zero: assert property (!min_reg[7]) else $error("minutes bit 7 set");
  a_wday_wraps: assert property (do_inc && !wr_evt && c_day && wday_reg == 8'h06 |=> wday_reg == 8'h00)
    else $error("weekday did not wrap");
  a_leap_day: assert property (do_inc && !wr_evt && c_day && mon_reg == FEB_BCD && day_reg == DAYS_28
    && leap_year(year_reg) |=> day_reg == DAYS_29) else $error("leap day skipped");

  c_tick_blocked: cover property (blocked && tick_evt);
  c_os_cleared: cover property (os_reg ##1 !os_reg);
  c_year_roll: cover property (do_inc && c_year);
  c_leap_day: cover property (day_reg == DAYS_29 && mon_reg == FEB_BCD);

endmodule // rtc_time_date_counters

// ---- verification/rtc_host_model.sv ----
`timescale 1ns/1ps
module rtc_host_model (
  input  wire logic       link_clk_i,
  input  wire logic       busy_i,
  input  wire logic [7:0] rdata_i,
  output logic            access_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o
);
  initial
  begin
    access_o = 1'b0;
    addr_o   = 8'h00;
    wdata_o  = 8'h00;
    wr_o     = 1'b0;
    rd_o     = 1'b0;
  end

  // Each access lasts microseconds, far inside one tick period
  task automatic acc(input logic v);
    @(negedge link_clk_i);
    access_o = v;
    repeat (3) @(negedge link_clk_i);
  endtask

  // Released lines carry the inverse so stale values cannot pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(negedge link_clk_i);
    while (busy_i !== 1'b0 && n < 40)
    begin
      @(negedge link_clk_i);
      n++;
    end
    addr_o  = a;
    wdata_o = d;
    wr_o    = w;
    rd_o    = ~w;
    @(negedge link_clk_i);
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
    @(negedge link_clk_i);
    while (busy_i !== 1'b0 && n < 40)
    begin
      @(negedge link_clk_i);
      n++;
    end
    q = rdata_i;
  endtask
endmodule // rtc_host_model

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
  import rtc_pkg::*;
  typedef struct packed {logic m; logic [55:0] a; logic [55:0] b;} row_t;
  logic       clk_i = 1'b0;
  logic       link_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       tick = 1'b0;
  logic       osc = 1'b0;
  logic       h12;
  logic       acc_s, wr_s, rd_s, busy, flag;
  logic [7:0] addr_s, wdata_s, rdata;
  int         failures = 0;
  int         checked = 0;
  int         cycles = 0;
  logic [7:0] msk [5] = '{MIN_MASK, HOUR_MASK, DAY_MASK, WDAY_MASK, MON_MASK};
  // Order: seconds, minutes, hours, days, weekday, month, year
  row_t rows [10] = '{
    '{1'b0, 56'h59592328060204, 56'h00000029000204},
    '{1'b0, 56'h59592328030201, 56'h00000001040301},
    '{1'b0, 56'h59592331051299, 56'h00000001060100},
    '{1'b0, 56'h59592330020405, 56'h00000001030505},
    '{1'b0, 56'h59592329000200, 56'h00000001010300},
    '{1'b1, 56'h59591115010705, 56'h00003215010705},
    '{1'b1, 56'h59593115010705, 56'h00001216020705},
    '{1'b0, 56'h59591910000600, 56'h00002010000600},
    '{1'b0, 56'h59090001000100, 56'h00100001000100},
    '{1'b0, 56'h09000001000100, 56'h10000001000100}
  };

  always #12.5 clk_i = ~clk_i;
  initial
  begin
    #7;
    forever #62.5 link_clk_i = ~link_clk_i;
  end

  rtc_time_date_counters dut (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .tick_1hz_i      (tick),
    .osc_running_i   (osc),
    .hour_12_mode_i  (h12),
    .link_clk_i      (link_clk_i),
    .access_active_i (acc_s),
    .reg_addr_i      (addr_s),
    .reg_wdata_i     (wdata_s),
    .reg_wr_i        (wr_s),
    .reg_rd_i        (rd_s),
    .reg_rdata_o     (rdata),
    .reg_busy_o      (busy),
    .osc_halt_flag_o (flag)
  );

  rtc_host_model host (
    .link_clk_i (link_clk_i),
    .busy_i     (busy),
    .rdata_i    (rdata),
    .access_o   (acc_s),
    .addr_o     (addr_s),
    .wdata_o    (wdata_s),
    .wr_o       (wr_s),
    .rd_o       (rd_s)
  );

  task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] s, input logic [7:0] e);
    checked++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, s, e);
    end
  endtask

  task automatic io(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    logic [7:0] q;
    if (w)
      host.xfer(1'b1, a, d, q);
    host.xfer(1'b0, a, 8'h00, q);
    check(q, e);
  endtask

  // Whole bank in one access so no carry splits it
  task automatic put(input logic [55:0] v);
    logic [7:0] q;
    host.acc(1'b1);
    for (int i = 0; i < 7; i++)
      host.xfer(1'b1, SEC_ADDR + 8'(i), v[55-8*i -: 8], q);
    host.acc(1'b0);
  endtask

  task automatic get_all(input logic [55:0] e);
    logic [7:0] q;
    host.acc(1'b1);
    for (int i = 0; i < 7; i++)
    begin
      host.xfer(1'b0, SEC_ADDR + 8'(i), 8'h00, q);
      check(q, e[55-8*i -: 8]);
    end
    host.acc(1'b0);
  endtask

  task automatic tick1();
    @(negedge clk_i);
    tick = 1'b1;
    repeat (4) @(negedge clk_i);
    tick = 1'b0;
    repeat (8) @(negedge clk_i);
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      results();
    end
  end

  initial
  begin
    h12 = 1'b0;
    // Link reset passes a synchroniser, so hold past four link edges
    repeat (24) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge link_clk_i);
    for (int r = 0; r < 10; r++)
    begin
      @(negedge clk_i);
      h12 = rows[r].m;
      osc = 1'b1;
      put(rows[r].a);
      tick1();
      get_all(rows[r].b);
    end
    @(negedge clk_i);
    h12 = 1'b0;
    rst_i = 1'b1;
    osc = 1'b0;
    repeat (24) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge link_clk_i);
    get_all(56'h80000001060100);
    check({7'h00, flag}, 8'h01);
    io(1'b1, SEC_ADDR, 8'h00, 8'h80);
    @(negedge clk_i);
    osc = 1'b1;
    repeat (8) @(negedge clk_i);
    io(1'b1, SEC_ADDR, 8'h00, 8'h00);
    check({7'h00, flag}, 8'h00);
    osc = 1'b0;
    repeat (8) @(negedge clk_i);
    osc = 1'b1;
    repeat (40) @(negedge clk_i);
    check({7'h00, flag}, 8'h01);
    io(1'b0, SEC_ADDR, 8'h00, 8'h80);
    for (int i = 0; i < 5; i++)
      io(1'b1, MIN_ADDR + 8'(i), 8'hff, msk[i]);
    io(1'b1, YEAR_ADDR, 8'h99, 8'h99);
    io(1'b1, 8'h03, 8'h5a, 8'h00);
    io(1'b1, 8'h0b, 8'h5a, 8'h00);
    put(56'h10000001000100);
    host.acc(1'b1);
    tick1();
    tick1();
    io(1'b0, SEC_ADDR, 8'h00, 8'h10);
    host.acc(1'b0);
    io(1'b0, SEC_ADDR, 8'h00, 8'h11);
    results();
  end
endmodule // tb
